// File: src/lsd_map.vh
`ifndef LSD_MAP_VH
`define LSD_MAP_VH

// Duty selection codes; code 2'h3 is reserved and treated as disabled.
`define LSD_DUTY_STATIC    2'h0
`define LSD_DUTY_THIRD     2'h1
`define LSD_DUTY_QUARTER   2'h2

// Last phase index of a frame for each duty.
`define LSD_LAST_STATIC    2'h0
`define LSD_LAST_THIRD     2'h2
`define LSD_LAST_QUARTER   2'h3

// Drive level codes for each output pin.
`define LSD_LVL_SUPPLY     2'h0
`define LSD_LVL_TWO_THIRD  2'h1
`define LSD_LVL_ONE_THIRD  2'h2
`define LSD_LVL_BIAS       2'h3
`define LSD_LVL_W          2

// Frontplane and segment storage geometry.
`define LSD_NUM_FP         27
`define LSD_NUM_SEG_REGS   14
`define LSD_SEG_NIBBLE     4
`define LSD_PORT_LOW_FIRST 19
`define LSD_PORT_HIGH_FIRST 23

// Base clock divide: crystal edges per base tick is 2 to the power (code + 1).
`define LSD_DIV_CNT_W      8
`define LSD_DIV_ONE        8'h01

`endif

// File: src/lsd_divider.v
`timescale 1ns/10ps
`default_nettype none
`include "lsd_map.vh"

// Turns the crystal reference into one-cycle base clock ticks.
module lsd_divider (
    input  wire                      clk,
    input  wire                      rst_b,
    input  wire                      crystal_ref_clock,
    input  wire                      run,
    input  wire [2:0]                base_clock_divider,
    output reg                       tick_q,
    output reg                       waveform_base_clock
);
    reg                       sync1_q;
    reg                       sync2_q;
    reg                       prev_q;
    reg [`LSD_DIV_CNT_W-1:0]  cnt_q;
    wire [`LSD_DIV_CNT_W-1:0] last;
    wire                      ref_rise;

    // The reference comes from another clock and is synchronised first.
    assign last     = (`LSD_DIV_ONE << base_clock_divider) + (`LSD_DIV_ONE << base_clock_divider)
                      - `LSD_DIV_ONE; // see RULE14
    assign ref_rise = sync2_q & ~prev_q;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_q             <= 1'b0;
            sync2_q             <= 1'b0;
            prev_q              <= 1'b0;
            cnt_q               <= {`LSD_DIV_CNT_W{1'b0}};
            tick_q              <= 1'b0;
            waveform_base_clock <= 1'b0;
        end else begin
            sync1_q <= crystal_ref_clock;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
            tick_q  <= 1'b0;
            if (!run) begin
                cnt_q               <= {`LSD_DIV_CNT_W{1'b0}};
                waveform_base_clock <= 1'b0;
            end else if (ref_rise) begin
                if (cnt_q >= last) begin
                    cnt_q               <= {`LSD_DIV_CNT_W{1'b0}};
                    tick_q              <= 1'b1; // see RULE14
                    waveform_base_clock <= ~waveform_base_clock;
                end else begin
                    cnt_q <= cnt_q + `LSD_DIV_ONE;
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: src/lsd_driver.v
// What this block does
// RULE1: Up to 27 frontplanes and 4 backplanes.
// RULE2: Configurations 26x4, 27x3 and 27x1 segments.
// RULE3: Shared pin is frontplane 0 or backplane 3.
// RULE4: Frontplanes 19-26 given to LCD by two selects.
// RULE5: One-third bias, four drive levels per output.
// RULE6: Fourteen data registers, two frontplanes each.
// RULE7: Bit one turns segment on, zero off.
// RULE8: Disabled holds every output at supply.
// RULE9: Disabled disconnects the bias ladder.
// RULE10: Static drives backplane 0; quarter drives all four.
// RULE11: One-third duty drives backplanes 0, 1, 2.
// RULE12: Enabled backplanes output periodic duty waveforms.
// RULE13: Contrast field selects the bias level.
// RULE14: Base clock divides crystal reference by field.
// RULE15: Frame is one base period per phase.
// RULE16: Backplane 3 only in quarter duty.
// RULE17: Reset leaves the driver disabled.
// RULE18: Duty and divider codes named; unused codes reserved.
// RULE19: Frontplane level from phase and segment bits.
`timescale 1ns/10ps
`default_nettype none
`include "lsd_map.vh"

module lsd_driver (
    input  wire                      clk,
    input  wire                      rst_b,
    input  wire                      crystal_ref_clock,
    input  wire                      driver_enable,
    input  wire [1:0]                duty_select,
    input  wire [2:0]                base_clock_divider,
    input  wire [3:0]                contrast_field,
    input  wire                      port_low_lcd_select,
    input  wire                      port_high_lcd_select,
    input  wire                      seg_wr_en,
    input  wire [3:0]                seg_wr_index,
    input  wire [7:0]                seg_wr_data,
    input  wire [3:0]                seg_rd_index,
    output reg  [7:0]                seg_rd_data,
    output reg  [5:0]                backplane_pins,
    output reg  [1:0]                shared_plane_pin,
    output reg  [35:0]               dedicated_frontplane_pins,
    output reg  [15:0]               port_shared_frontplanes,
    output reg  [7:0]                port_lcd_own,
    output reg                       ladder_disconnect,
    output reg  [3:0]                bias_select,
    output wire                      waveform_base_clock
);
    reg  [7:0]                       seg_mem_q [0:`LSD_NUM_SEG_REGS-1];
    reg                              en_q;
    reg  [1:0]                       phase_q;
    reg                              pol_q;
    reg  [1:0]                       last_phase;
    reg                              duty_ok;
    wire                             run;
    wire                             tick;
    wire [`LSD_NUM_FP*2-1:0]         fp_lvl;
    wire [7:0]                       bp_lvl;
    reg  [1:0]                       phase_d;
    reg                              pol_d;
    wire                             seg_wr_ok;
    reg  [7:0]                       seg_rd_d;
    reg  [5:0]                       bp_pins_d;
    reg  [1:0]                       shared_pin_d;
    reg  [35:0]                      ded_fp_d;
    reg  [15:0]                      port_fp_d;
    integer                          k;

    // A reserved duty code leaves the display dark like a disabled driver.
    always @* begin
        duty_ok    = 1'b1;
        last_phase = `LSD_LAST_STATIC;
        case (duty_select)
            `LSD_DUTY_STATIC: begin
                last_phase = `LSD_LAST_STATIC; // see RULE15
            end
            `LSD_DUTY_THIRD: begin
                last_phase = `LSD_LAST_THIRD; // see RULE15
            end
            `LSD_DUTY_QUARTER: begin
                last_phase = `LSD_LAST_QUARTER; // see RULE15
            end
            default: begin
                duty_ok = 1'b0; // see RULE18
            end
        endcase
    end

    assign run = en_q & duty_ok;

    lsd_divider u_div (
        .clk                 (clk),
        .rst_b               (rst_b),
        .crystal_ref_clock   (crystal_ref_clock),
        .run                 (run),
        .base_clock_divider  (base_clock_divider),
        .tick_q              (tick),
        .waveform_base_clock (waveform_base_clock)
    );

    // Backplane n is selected in phase n; polarity flips each frame to keep
    // the panel free of DC.
    genvar b;
    generate
        for (b = 0; b < 4; b = b + 1) begin : g_bp
            wire sel = (phase_q == b);
            assign bp_lvl[b*2 +: 2] = sel ? (pol_q ? `LSD_LVL_BIAS : `LSD_LVL_SUPPLY)
                                          : (pol_q ? `LSD_LVL_TWO_THIRD
                                                   : `LSD_LVL_ONE_THIRD); // see RULE5
        end
    endgenerate

    // Frontplane i reads nibble i%2 of register i/2, bit by current phase.
    genvar f;
    generate
        for (f = 0; f < `LSD_NUM_FP; f = f + 1) begin : g_fp
            wire [7:0] word = seg_mem_q[f/2];
            wire       on   = word[(f%2)*`LSD_SEG_NIBBLE + phase_q]; // see RULE6
            wire [1:0] stat = on ? (pol_q ? `LSD_LVL_SUPPLY : `LSD_LVL_BIAS)
                                 : bp_lvl[1:0];
            wire [1:0] mux  = on ? (pol_q ? `LSD_LVL_SUPPLY : `LSD_LVL_BIAS)
                                 : (pol_q ? `LSD_LVL_ONE_THIRD
                                          : `LSD_LVL_TWO_THIRD); // see RULE7
            assign fp_lvl[f*2 +: 2] = (duty_select == `LSD_DUTY_STATIC) ? stat
                                                                        : mux; // see RULE19
        end
    endgenerate

    // Next phase and polarity; a stopped driver restarts at phase 0.
    always @* begin
        phase_d = phase_q;
        pol_d   = pol_q;
        if (!run) begin
            phase_d = 2'h0;
            pol_d   = 1'b0;
        end else if (tick) begin
            if (phase_q >= last_phase) begin
                phase_d = 2'h0; // see RULE15
                pol_d   = ~pol_q;
            end else begin
                phase_d = phase_q + 2'h1; // see RULE12
            end
        end
    end

    // Writes to an index past the last data register are dropped.
    assign seg_wr_ok = seg_wr_en && (seg_wr_index < `LSD_NUM_SEG_REGS);

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (k = 0; k < `LSD_NUM_SEG_REGS; k = k + 1) begin
                seg_mem_q[k] <= 8'h00;
            end
            en_q    <= 1'b0; // see RULE17
            phase_q <= 2'h0;
            pol_q   <= 1'b0;
        end else begin
            en_q    <= driver_enable;
            phase_q <= phase_d;
            pol_q   <= pol_d;
            if (seg_wr_ok) begin
                seg_mem_q[seg_wr_index] <= seg_wr_data; // see RULE6
            end
        end
    end

    // Unmapped read indexes return zero.
    always @* begin
        seg_rd_d = 8'h00;
        if (seg_rd_index < `LSD_NUM_SEG_REGS) begin
            seg_rd_d = seg_mem_q[seg_rd_index]; // see RULE6
        end
    end

    // Next pin levels. A stopped driver parks every pin at supply, and
    // backplanes that the duty leaves unused rest at supply as well.
    always @* begin
        bp_pins_d    = 6'h00; // see RULE8
        shared_pin_d = `LSD_LVL_SUPPLY;
        ded_fp_d     = 36'h0;
        port_fp_d    = 16'h0000;
        if (run) begin
            bp_pins_d[1:0] = bp_lvl[1:0]; // see RULE10
            if (duty_select != `LSD_DUTY_STATIC) begin
                bp_pins_d[3:2] = bp_lvl[3:2]; // see RULE11
                bp_pins_d[5:4] = bp_lvl[5:4]; // see RULE11
            end
            if (duty_select == `LSD_DUTY_QUARTER) begin
                shared_pin_d = bp_lvl[7:6]; // see RULE16
            end else begin
                shared_pin_d = fp_lvl[1:0]; // see RULE3
            end
            ded_fp_d = fp_lvl[37:2]; // see RULE1, RULE2
            if (port_low_lcd_select) begin
                port_fp_d[7:0] = fp_lvl[45:38]; // see RULE4
            end
            if (port_high_lcd_select) begin
                port_fp_d[15:8] = fp_lvl[53:46]; // see RULE4
            end
        end
    end

    // All pins are registered so that every output switches on the same edge.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            seg_rd_data               <= 8'h00;
            backplane_pins            <= 6'h00;
            shared_plane_pin          <= `LSD_LVL_SUPPLY;
            dedicated_frontplane_pins <= 36'h0;
            port_shared_frontplanes   <= 16'h0000;
            port_lcd_own              <= 8'h00;
            ladder_disconnect         <= 1'b1;
            bias_select               <= 4'h0;
        end else begin
            seg_rd_data               <= seg_rd_d;
            backplane_pins            <= bp_pins_d;
            shared_plane_pin          <= shared_pin_d;
            dedicated_frontplane_pins <= ded_fp_d;
            port_shared_frontplanes   <= port_fp_d;
            port_lcd_own              <= {{4{port_high_lcd_select}},
                                          {4{port_low_lcd_select}}}; // see RULE4
            ladder_disconnect         <= ~run; // see RULE9
            bias_select               <= contrast_field; // see RULE13
        end
    end
endmodule
`default_nettype wire

// File: bench/lsd_panel.sv
`timescale 1ns/10ps
`default_nettype none
module lsd_panel (
    input wire logic         clk,
    input wire logic         clr,
    input wire logic [7:0]   bp,
    input wire logic [53:0]  fp,
    output logic     [107:0] lit
);
    // A segment counts as lit once the full supply stands across it; supply and bias
    // are the only pair of codes that lie three steps apart.
    always @(posedge clk) begin
        for (int f = 0; f < 27; f++) begin
            for (int b = 0; b < 4; b++) begin
                if (clr)
                    lit[f*4+b] <= 1'h0;
                else if ((fp[f*2+:2] ^ bp[b*2+:2]) == 2'h3 && fp[f*2] == fp[f*2+1])
                    lit[f*4+b] <= 1'h1;
            end
        end
    end
endmodule
`default_nettype wire

// File: bench/lsd_driver_properties.sv
`timescale 1ns/10ps
`default_nettype none
module lsd_driver_chk (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        driver_enable,
    input wire logic [1:0]  duty_select,
    input wire logic [3:0]  contrast_field,
    input wire logic        port_low_lcd_select,
    input wire logic        port_high_lcd_select,
    input wire logic [3:0]  seg_rd_index,
    input wire logic [7:0]  seg_rd_data,
    input wire logic [5:0]  backplane_pins,
    input wire logic [1:0]  shared_plane_pin,
    input wire logic [15:0] port_shared_frontplanes,
    input wire logic [7:0]  port_lcd_own,
    input wire logic        ladder_disconnect,
    input wire logic [3:0]  bias_select
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // A backplane at supply or bias is the one selected in this phase.
    wire [3:0] bsel;
    assign bsel = {~^shared_plane_pin, ~^backplane_pins[5:4], ~^backplane_pins[3:2],
                   ~^backplane_pins[1:0]};
    off_supply_a: assert property (!driver_enable ##1 !driver_enable |=>
        backplane_pins == 6'h00 && shared_plane_pin == 2'h0) else $error("pins off supply");
    ladder_off_a: assert property (!driver_enable ##1 !driver_enable |=>
        ladder_disconnect) else $error("ladder still connected");
    bias_copy_a: assert property ($past(rst_b, 2) |->
        bias_select == $past(contrast_field)) else $error("bias select wrong");
    port_own_a: assert property ($past(rst_b, 2) |-> port_lcd_own ==
        {{4{$past(port_high_lcd_select)}}, {4{$past(port_low_lcd_select)}}})
        else $error("port ownership wrong");
    port_off_a: assert property (!port_high_lcd_select ##1 !port_high_lcd_select |=>
        port_shared_frontplanes[15:8] == 8'h00) else $error("released port driven");
    rd_range_a: assert property (seg_rd_index > 4'hD |=> seg_rd_data == 8'h00)
        else $error("unmapped read not zero");
    quarter_sel_a: assert property ((driver_enable && duty_select == 2'h2) [*4] |->
        $onehot(bsel)) else $error("quarter backplane select");
    third_sel_a: assert property ((driver_enable && duty_select == 2'h1) [*4] |->
        $onehot(bsel[2:0])) else $error("third backplane select");
    cover property (driver_enable && duty_select == 2'h0);
    cover property (driver_enable && duty_select == 2'h1);
    cover property (driver_enable && duty_select == 2'h2);
endmodule
bind lsd_driver lsd_driver_chk i_chk (.*);
`default_nettype wire

// File: bench/lsd_driver_tb.sv
`timescale 1ns/10ps
`default_nettype none
module lsd_driver_tb;
    logic         clk = 1'h0, rst_b = 1'h0, crystal_ref_clock = 1'h0, driver_enable = 1'h0;
    logic         port_low_lcd_select = 1'h0, port_high_lcd_select = 1'h0;
    logic         seg_wr_en = 1'h0, clr = 1'h0, ladder_disconnect, waveform_base_clock;
    logic [1:0]   duty_select = 2'h0, shared_plane_pin;
    logic [2:0]   base_clock_divider = 3'h0;
    logic [3:0]   contrast_field = 4'h0, seg_wr_index = 4'h0, seg_rd_index = 4'h0, bias_select;
    logic [7:0]   seg_wr_data = 8'h00, seg_rd_data, port_lcd_own;
    logic [5:0]   backplane_pins;
    logic [35:0]  dedicated_frontplane_pins;
    logic [15:0]  port_shared_frontplanes;
    logic [107:0] lit;
    int           n_fail = 0, n_checks = 0, cyc = 0;
    time          t0;
    lsd_driver i_dut (.clk, .rst_b, .crystal_ref_clock, .driver_enable, .duty_select,
        .base_clock_divider, .contrast_field, .port_low_lcd_select, .port_high_lcd_select,
        .seg_wr_en, .seg_wr_index, .seg_wr_data, .seg_rd_index, .seg_rd_data, .backplane_pins,
        .shared_plane_pin, .dedicated_frontplane_pins, .port_shared_frontplanes, .port_lcd_own,
        .ladder_disconnect, .bias_select, .waveform_base_clock);
    // The shared pin is always wired as frontplane 0, and also as backplane 3 on a quarter-duty panel.
    lsd_panel i_panel (.clk, .clr, .lit,
        .bp({duty_select == 2'h2 ? shared_plane_pin : 2'h0, backplane_pins}),
        .fp({port_shared_frontplanes, dedicated_frontplane_pins, shared_plane_pin}));
    initial forever #5 clk = ~clk;
    initial forever #40 crystal_ref_clock = ~crystal_ref_clock;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_fail++;
            close_out();
        end
    end
    task automatic check(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    function automatic logic [7:0] pat(input int i);
        return 8'(i * 8'h25) ^ 8'h5A;
    endfunction
    function automatic logic ex(input int f, input int b);
        logic [7:0] p;
        p = pat(f / 2);
        return p[(f % 2) * 4 + b];
    endfunction
    task automatic wr(input int i);
        @(negedge clk);
        seg_wr_en = 1'h1;
        seg_wr_index = 4'(i);
        seg_wr_data = pat(i);
        @(negedge clk);
        seg_wr_en = 1'h0;
    endtask
    task automatic rd(input int i, input logic [7:0] e);
        @(negedge clk);
        seg_rd_index = 4'(i);
        @(negedge clk);
        check(seg_rd_data === e, "segment readback");
    endtask
    initial begin
        repeat (4) @(negedge clk);
        check(ladder_disconnect === 1'h1 && backplane_pins === 6'h00, "reset");
        rst_b = 1'h1;
        for (int i = 0; i < 15; i++) wr(i);
        for (int i = 0; i < 15; i++) rd(i, i < 14 ? pat(i) : 8'h00);
        $display("test storage done");
        port_low_lcd_select = 1'h1;
        port_high_lcd_select = 1'h1;
        for (int d = 0; d < 3; d++) begin
            duty_select = 2'(d);
            contrast_field = 4'hA ^ 4'(d);
            driver_enable = 1'h1;
            clr = 1'h1;
            repeat (6) @(negedge clk);
            clr = 1'h0;
            repeat (300) @(negedge clk);
            for (int f = 0; f < 27; f++)
                for (int b = 0; b < (d == 0 ? 1 : d + 2); b++)
                    if (d != 2 || f != 0)
                        check(lit[f*4+b] === ex(f, b), "segment drive");
            check(bias_select === (4'hA ^ 4'(d)), "contrast to bias");
            driver_enable = 1'h0;
            repeat (3) @(negedge clk);
            check(backplane_pins === 6'h00 && shared_plane_pin === 2'h0 && ladder_disconnect
                === 1'h1 && dedicated_frontplane_pins === 36'h0, "disabled");
            $display("test duty %0d done", d);
        end
        port_high_lcd_select = 1'h0;
        repeat (3) @(negedge clk);
        check(port_lcd_own === 8'h0F, "port select");
        $display("test port done");
        duty_select = 2'h3;
        driver_enable = 1'h1;
        repeat (40) @(negedge clk);
        check(ladder_disconnect === 1'h1 && backplane_pins === 6'h00, "reserved duty");
        duty_select = 2'h2;
        $display("test reserved duty done");
        driver_enable = 1'h1;
        for (int c = 0; c < 8; c++) begin
            @(negedge clk);
            base_clock_divider = 3'(c);
            repeat (2) @(waveform_base_clock);
            t0 = $time;
            @(waveform_base_clock);
            check($time - t0 == 160 * (1 << c), "base clock period");
        end
        $display("test divider done");
        close_out();
    end
endmodule
`default_nettype wire
